// ===== rtl/pgw_guard.sv
// Program memory write guard: access decisions, config shadow, serial pin routing.
// Assumes the flash sequencer and serial port give one-cycle request strobes.
`timescale 1ns/1ps
module pgw_guard
    import pgw_pkg::*;
#(
    parameter pgw_pkg::pgw_addr_t LAST_ADDR = 24'h00ABFF,
    parameter int                 PAIRS     = 3
) (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           nrst,
    // Avalon-MM slave
    input  wire logic [3:0]                     address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [31:0]                    writedata,
    input  wire logic [3:0]                     byteenable,
    output logic      [31:0]                    readdata,
    output logic                                waitrequest,
    // Interrupt and reset request
    output logic                                irq,
    output logic                                device_reset_req,
    // Internal write/erase sequencer
    input  wire logic                           int_req,
    input  wire logic [pgw_pkg::ADDR_W-1:0]     int_addr,
    output logic                                int_ack,
    output logic                                int_allowed,
    output logic                                interlock_armed,
    // External programming/debug access
    input  wire logic                           ext_req,
    input  wire logic                           ext_write,
    input  wire logic [pgw_pkg::ADDR_W-1:0]     ext_addr,
    output logic                                ext_ack,
    output logic                                ext_allowed,
    // Serial programming pins
    input  wire logic [PAIRS-1:0]               program_clock_pin,
    input  wire logic [PAIRS-1:0]               program_data_pin_in,
    output logic      [PAIRS-1:0]               program_data_pin_out,
    output logic      [PAIRS-1:0]               program_data_pin_oe,
    // Serial programming engine side
    output logic                                ser_clock,
    output logic                                ser_data_in,
    input  wire logic                           ser_data_out,
    input  wire logic                           ser_data_oe,
    // Debug resource reservation
    input  wire logic [pgw_pkg::RAM_ADDR_W-1:0] ram_addr,
    output logic                                ram_user_blocked,
    output logic      [PAIRS-1:0]               pin_reserved
);
    import pgw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic              int_ack;
        logic              int_allowed;
        logic              ext_ack;
        logic              ext_allowed;
        logic              rst_req;
    } pgw_guard_s;

    pgw_guard_s q, d;

    ////////////////////////////////////////////////////////////////////////////
    // Register select

    logic sel_config;
    logic sel_status;
    logic sel_mask;
    logic sel_fault;
    logic be_word;
    logic be_low3;

    assign sel_config = (address == OFF_CONFIG);
    assign sel_status = (address == OFF_STATUS);
    assign sel_mask   = (address == OFF_MASK);
    assign sel_fault  = (address == OFF_FAULT);
    assign be_word    = (byteenable == 4'hF);
    assign be_low3    = &byteenable[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration with shadow

    logic [CFG_W-1:0] cfg;
    logic             cfg_mismatch;
    logic             cfg_wr;
    logic [CFG_W-1:0] cfg_wdata;
    logic [CFG_W-1:0] cfg_upset;
    logic             cfg_wr_ok;
    logic             bus_wr;
    logic             bus_rd_next;

    logic                  read_lock_on;
    logic                  write_lock_on;
    logic                  seg_off;
    logic                  bound_sel;
    logic                  last_guard;
    logic [PAGE_IDX_W-1:0] page_idx;
    logic                  debug_en;
    logic [PAIR_W-1:0]     pair_sel;

    assign read_lock_on  = !cfg[CF_READ_LOCK];
    assign write_lock_on = !cfg[CF_WRITE_LOCK];
    assign seg_off       = cfg[CF_SEG_OFF];
    assign bound_sel     = cfg[CF_BOUND_SEL];
    assign last_guard    = cfg[CF_LAST_GUARD];
    assign page_idx      = cfg[CF_PAGE_LSB +: PAGE_IDX_W];
    assign debug_en      = cfg[CF_DEBUG_EN];
    assign pair_sel      = cfg[CF_PAIR_LSB +: PAIR_W];

    // Bus write lands in the cycle waitrequest drops
    assign bus_wr      = write && q.ack;
    assign bus_rd_next = read && !q.ack;

    // Config words live in the last page, so they share its protection
    assign cfg_wr_ok = !write_lock_on && last_guard && (seg_off || !bound_sel);

    assign cfg_wr    = bus_wr && sel_config && cfg_wr_ok && be_word;
    assign cfg_wdata = writedata[CFG_W-1:0] & CFG_MASK;
    assign cfg_upset = (bus_wr && sel_fault && be_low3) ? writedata[CFG_W-1:0] : '0;

    pgw_shadow_reg #(
        .WIDTH    (CFG_W),
        .RESET    (CFG_RESET)
    ) u_cfg (
        .clock    (clock),
        .nrst     (nrst),
        .wr_en    (cfg_wr),
        .wr_data  (cfg_wdata),
        .upset    (cfg_upset),
        .value    (cfg),
        .mismatch (cfg_mismatch)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Protection decode

    logic seg_hit;
    logic last_hit;
    logic int_block;
    logic ext_block;

    pgw_range_check #(
        .LAST_ADDR  (LAST_ADDR)
    ) u_range (
        .addr       (int_addr),
        .seg_off    (seg_off),
        .bound_sel  (bound_sel),
        .last_guard (last_guard),
        .page_idx   (page_idx),
        .seg_hit    (seg_hit),
        .last_hit   (last_hit)
    );

    // Union of global lock and segment guards
    assign int_block = write_lock_on || seg_hit || last_hit;

    // Covers all addresses, config source included
    assign ext_block = read_lock_on;

    ////////////////////////////////////////////////////////////////////////////
    // Status events and clears

    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] w1c;
    logic [31:0]     rd_mux;

    always_comb
    begin
        ev                 = '0;
        ev[ST_EXT_REFUSED] = ext_req && ext_block;
        ev[ST_INT_BLOCKED] = int_req && int_block;
        ev[ST_PARITY]      = cfg_mismatch;
        ev[ST_CFG_REFUSED] = bus_wr && sel_config && !cfg_wr_ok;
    end

    always_comb
    begin
        w1c = '0;
        if (bus_wr && sel_status && byteenable[0])
        begin
            w1c = writedata[ST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data select

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (address)
            OFF_CONFIG: rd_mux = {{(32-CFG_W){1'b0}}, cfg};
            OFF_STATUS: rd_mux = {{(32-ST_W){1'b0}}, q.status};
            OFF_MASK:   rd_mux = {{(32-ST_W){1'b0}}, q.mask};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        d = q;

        // One wait cycle, then the answer
        d.ack = (read || write) && !q.ack;
        if (bus_rd_next)
        begin
            d.rdata = rd_mux;
        end

        // Set wins over clear
        d.status = (q.status & ~w1c) | ev;

        if (bus_wr && sel_mask && byteenable[0])
        begin
            d.mask = writedata[ST_W-1:0];
        end

        // Decision taken before the sequencer may start
        d.int_ack = int_req;
        if (int_req)
        begin
            d.int_allowed = !int_block;
        end

        d.ext_ack = ext_req;
        if (ext_req)
        begin
            d.ext_allowed = !ext_block;
        end

        d.rst_req = cfg_mismatch;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            q.ack         <= 1'b0;
            q.rdata       <= 32'h0000_0000;
            q.status      <= ST_RESET;
            q.mask        <= ST_RESET;
            q.int_ack     <= 1'b0;
            q.int_allowed <= 1'b0;
            q.ext_ack     <= 1'b0;
            q.ext_allowed <= 1'b0;
            q.rst_req     <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin pair decode

    // Select values at or above PAIRS pick no pair
    logic [PAIRS-1:0] pair_hit;

    always_comb
    begin
        pair_hit = '0;
        for (int i = 0; i < PAIRS; i++)
        begin
            if (pair_sel == i[PAIR_W-1:0])
            begin
                pair_hit[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial programming pin pair select

    always_comb
    begin
        ser_clock   = 1'b0;
        ser_data_in = 1'b0;
        for (int i = 0; i < PAIRS; i++)
        begin
            if (pair_hit[i])
            begin
                ser_clock   = program_clock_pin[i];
                ser_data_in = program_data_pin_in[i];
            end
        end
    end

    // Unselected pairs are never driven
    always_comb
    begin
        program_data_pin_out = '0;
        program_data_pin_oe  = '0;
        for (int i = 0; i < PAIRS; i++)
        begin
            if (pair_hit[i])
            begin
                program_data_pin_out[i] = ser_data_out;
                program_data_pin_oe[i]  = ser_data_oe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug reservation

    always_comb
    begin
        pin_reserved = '0;
        for (int i = 0; i < PAIRS; i++)
        begin
            if (debug_en && pair_hit[i])
                pin_reserved[i] = 1'b1;
        end
    end

    assign ram_user_blocked = debug_en && (ram_addr < DBG_RAM_BYTES);

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign waitrequest      = (read || write) && !q.ack;
    assign readdata         = q.rdata;

    assign irq              = |(q.status & q.mask);
    assign device_reset_req = q.rst_req;

    assign int_ack          = q.int_ack;
    assign int_allowed      = q.int_allowed;
    assign interlock_armed  = q.int_allowed;

    assign ext_ack          = q.ext_ack;
    assign ext_allowed      = q.ext_allowed;

endmodule : pgw_guard

// ===== rtl/pgw_pkg.sv
// Constants, register map and types for the program memory write guard.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
package pgw_pkg;

    localparam int          ADDR_W        = 24;
    localparam int          PAGE_SHIFT    = 9;
    localparam int          PAGE_IDX_W    = 6;
    localparam int          PAIR_W        = 2;
    localparam int          RAM_ADDR_W    = 16;
    localparam logic [15:0] DBG_RAM_BYTES = 16'h0050;

    // Register byte offsets
    localparam logic [3:0] OFF_CONFIG = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK   = 4'h8;
    localparam logic [3:0] OFF_FAULT  = 4'hC;

    // Config field positions
    localparam int CF_READ_LOCK  = 0;
    localparam int CF_WRITE_LOCK = 1;
    localparam int CF_SEG_OFF    = 2;
    localparam int CF_BOUND_SEL  = 3;
    localparam int CF_LAST_GUARD = 4;
    localparam int CF_PAGE_LSB   = 8;
    localparam int CF_DEBUG_EN   = 16;
    localparam int CF_PAIR_LSB   = 17;
    localparam int CFG_W         = 19;

    // Erased flash: every field bit one except debug enable and pair select, which are zero
    localparam logic [CFG_W-1:0] CFG_RESET = 19'h03F1F;
    localparam logic [CFG_W-1:0] CFG_MASK  = 19'h7FF1F;

    // Status bit positions
    localparam int ST_EXT_REFUSED = 0;
    localparam int ST_INT_BLOCKED = 1;
    localparam int ST_PARITY      = 2;
    localparam int ST_CFG_REFUSED = 3;
    localparam int ST_W           = 4;
    localparam logic [ST_W-1:0] ST_RESET = 4'h0;

    typedef logic [ADDR_W-1:0] pgw_addr_t;

endpackage : pgw_pkg

// ===== rtl/pgw_range_check.sv
// Segment and last-page protection decode for one program address.
// Assumes word addresses; pages are 512 words; config words sit in the last page.
`timescale 1ns/1ps
module pgw_range_check
    import pgw_pkg::*;
#(
    parameter pgw_pkg::pgw_addr_t LAST_ADDR = 24'h00ABFF
) (
    // Address under test
    input  wire logic [pgw_pkg::ADDR_W-1:0]     addr,
    // Segment settings
    input  wire logic                           seg_off,
    input  wire logic                           bound_sel,
    input  wire logic                           last_guard,
    input  wire logic [pgw_pkg::PAGE_IDX_W-1:0] page_idx,
    // Decode
    output logic                                seg_hit,
    output logic                                last_hit
);
    localparam int PW = ADDR_W - PAGE_SHIFT;

    logic [PW-1:0] page;
    logic [PW-1:0] bound;
    logic [PW-1:0] last_page;

    assign page      = addr[ADDR_W-1:PAGE_SHIFT];
    assign bound     = {{(PW-PAGE_IDX_W){1'b0}}, page_idx};
    assign last_page = LAST_ADDR[ADDR_W-1:PAGE_SHIFT];

    always_comb
    begin
        seg_hit = 1'b0;
        if (!seg_off)
        begin
            if (bound_sel)
                seg_hit = (page >= bound);
            else
                seg_hit = (page <= bound);
        end
        last_hit = !last_guard && (page >= last_page);
    end
endmodule : pgw_range_check

// ===== rtl/pgw_shadow_reg.sv
// Configuration register with complement shadow and continuous compare.
// Assumes writes arrive as single-cycle strobes in the system clock domain.
`timescale 1ns/1ps
module pgw_shadow_reg #(
    parameter int                 WIDTH = 8,
    parameter logic [WIDTH-1:0]   RESET = '0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // Update and upset
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [WIDTH-1:0] upset,
    // Results
    output logic      [WIDTH-1:0] value,
    output logic                  mismatch
);
    typedef struct packed {
        logic [WIDTH-1:0] val;
        logic [WIDTH-1:0] shadow;
    } pgw_shadow_s;

    pgw_shadow_s q, d;

    always_comb
    begin
        d = q;
        if (wr_en)
        begin
            d.val    = wr_data;
            d.shadow = ~wr_data;
        end
        else
        begin
            d.shadow = q.shadow ^ upset;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            q.val    <= RESET;
            q.shadow <= ~RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign value    = q.val;
    assign mismatch = (q.val != ~q.shadow);
endmodule : pgw_shadow_reg

// ===== sim/pgw_flash_model.sv
// Model of the flash sequencer and the external programming port.
// Assumes each request is answered by an ack one cycle after it is taken.
`timescale 1ns/1ps
module pgw_flash_model (
    // Clock
    input  wire logic   clock,
    // Sequencer side
    output logic        int_req,
    output logic [23:0] int_addr,
    input  wire logic   int_ack,
    input  wire logic   int_allowed,
    // External side
    output logic        ext_req,
    output logic        ext_write,
    output logic [23:0] ext_addr,
    input  wire logic   ext_ack
);
    int commits = 0;
    initial
    begin
        int_req = 1'b0;
        int_addr = 24'h0;
        ext_req = 1'b0;
        ext_write = 1'b0;
        ext_addr = 24'h0;
    end

    task automatic int_op(input logic [23:0] a, input logic [1:0] gap);
        repeat (gap) @(posedge clock);
        int_req <= 1'b1;
        int_addr <= a;
        @(posedge clock);
        int_req <= 1'b0;
        int_addr <= ~a;
        do @(posedge clock); while (int_ack !== 1'b1);
        // Commit only what the guard let through
        if (int_allowed === 1'b1)
            commits++;
    endtask : int_op

    task automatic ext_op(input logic [23:0] a, input logic w);
        ext_req <= 1'b1;
        ext_write <= w;
        ext_addr <= a;
        @(posedge clock);
        ext_req <= 1'b0;
        ext_addr <= ~a;
        do @(posedge clock); while (ext_ack !== 1'b1);
    endtask : ext_op
endmodule : pgw_flash_model

// ===== sim/pgw_guard_monitor.sv
// Checker for the program memory write guard ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module pgw_guard_monitor
    import pgw_pkg::*;
#(
    parameter int PAIRS = 3
) (
    // Clock and reset
    input wire logic             clock,
    input wire logic             nrst,
    // Register bus
    input wire logic [3:0]       address,
    input wire logic             read,
    input wire logic             write,
    input wire logic [31:0]      writedata,
    input wire logic [3:0]       byteenable,
    input wire logic             waitrequest,
    input wire logic             device_reset_req,
    // Requests
    input wire logic             int_req,
    input wire logic             int_ack,
    input wire logic             int_allowed,
    input wire logic             interlock_armed,
    input wire logic             ext_req,
    input wire logic             ext_ack,
    input wire logic             ext_allowed,
    // Pins and debug
    input wire logic [PAIRS-1:0] program_data_pin_oe,
    input wire logic             ser_data_oe,
    input wire logic [15:0]      ram_addr,
    input wire logic             ram_user_blocked,
    input wire logic [PAIRS-1:0] pin_reserved
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_int_ack_next: assert property (int_req |=> int_ack)
        else $error("int_ack missing after int_req");
    a_int_ack_cause: assert property (!int_req |=> !int_ack)
        else $error("int_ack without int_req");
    a_ext_ack_next: assert property (ext_req |=> ext_ack)
        else $error("ext_ack missing after ext_req");
    a_int_hold: assert property (!int_req |=> $stable(int_allowed))
        else $error("int_allowed moved without request");
    a_ext_hold: assert property (!ext_req |=> $stable(ext_allowed))
        else $error("ext_allowed moved without request");
    a_interlock_same: assert property (interlock_armed == int_allowed)
        else $error("interlock differs from int_allowed");
    a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait cycle");
    a_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait cycle on new request");
    a_fault_reset: assert property (write && !waitrequest && address == 4'hC &&
        byteenable[2:0] == 3'h7 && writedata[4:0] != 5'h0 && !device_reset_req
        |-> ##[1:3] device_reset_req)
        else $error("shadow upset gave no reset request");
    a_ram_reserve: assert property (ram_user_blocked |-> ram_addr < 16'h0050)
        else $error("ram blocked above reserved bytes");
    a_pin_onehot: assert property ($onehot0(pin_reserved))
        else $error("more than one pair reserved");
    a_oe_follow: assert property (|program_data_pin_oe |->
        ser_data_oe && $onehot(program_data_pin_oe))
        else $error("data pin enable not from selected pair");
endmodule : pgw_guard_monitor

bind pgw_guard pgw_guard_monitor #(.PAIRS(PAIRS)) i_mon (
    .clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
    .device_reset_req(device_reset_req), .int_req(int_req), .int_ack(int_ack),
    .int_allowed(int_allowed), .interlock_armed(interlock_armed), .ext_req(ext_req),
    .ext_ack(ext_ack), .ext_allowed(ext_allowed), .program_data_pin_oe(program_data_pin_oe),
    .ser_data_oe(ser_data_oe), .ram_addr(ram_addr), .ram_user_blocked(ram_user_blocked),
    .pin_reserved(pin_reserved)
);

// ===== sim/pgw_guard_tb_top.sv
// Self-checking bench for the program memory write guard.
// Assumes the flash model issues the sequencer and external requests.
`timescale 1ns/1ps
module pgw_guard_tb_top;
    import pgw_pkg::*;
    logic        clock, int_req, ext_req, ext_write, waitrequest, irq, device_reset_req;
    logic        int_ack, int_allowed, interlock_armed, ext_ack, ext_allowed;
    logic        ser_clock, ser_data_in, ram_user_blocked;
    logic        nrst = 1'b0, read = 1'b0, write = 1'b0, ser_data_out = 1'b0, ser_data_oe = 1'b0;
    logic [3:0]  address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata;
    logic [23:0] int_addr, ext_addr;
    logic [2:0]  program_clock_pin = 3'h0, program_data_pin_in = 3'h0;
    logic [2:0]  pd_out, pd_oe, pin_reserved;
    logic [15:0] ram_addr = 16'h0, rnd = 16'h0007;
    logic [31:0] q_rd[$];
    logic        q_int[$], q_ext[$];
    int          errors = 0, samples_checked = 0, commits_exp = 0;

    pgw_guard i_dut (.clock(clock), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .device_reset_req(device_reset_req),
        .int_req(int_req), .int_addr(int_addr), .int_ack(int_ack), .int_allowed(int_allowed),
        .interlock_armed(interlock_armed), .ext_req(ext_req), .ext_write(ext_write),
        .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_allowed(ext_allowed),
        .program_clock_pin(program_clock_pin), .program_data_pin_in(program_data_pin_in),
        .program_data_pin_out(pd_out), .program_data_pin_oe(pd_oe), .ser_clock(ser_clock),
        .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
        .ram_addr(ram_addr), .ram_user_blocked(ram_user_blocked), .pin_reserved(pin_reserved));
    pgw_flash_model i_flash (.clock(clock), .int_req(int_req), .int_addr(int_addr),
        .int_ack(int_ack), .int_allowed(int_allowed), .ext_req(ext_req),
        .ext_write(ext_write), .ext_addr(ext_addr), .ext_ack(ext_ack));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic complete_run;
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        if (!wr)
            q_rd.push_back(e);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask : rd

    task automatic iop(input logic [23:0] a, input logic e);
        q_int.push_back(e);
        commits_exp += e;
        i_flash.int_op(a, rnd[1:0]);
    endtask : iop

    task automatic eop(input logic [23:0] a, input logic e);
        q_ext.push_back(e);
        i_flash.ext_op(a, rnd[0]);
    endtask : eop

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
    endtask : do_reset

    ////////////////////////////////////////
    // Random pin traffic and result watcher
    always @(posedge clock)
    begin
        rnd <= lfsr(rnd);
        program_clock_pin <= rnd[2:0];
        program_data_pin_in <= rnd[5:3];
        ser_data_out <= rnd[6];
        ser_data_oe <= rnd[7];
        if (int_ack === 1'b1)
            check("int_allowed", q_int.pop_front(), int_allowed);
        if (ext_ack === 1'b1)
            check("ext_allowed", q_ext.pop_front(), ext_allowed);
        if (read === 1'b1 && waitrequest === 1'b0)
            check("readdata", q_rd.pop_front(), readdata);
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run();
    end

    initial
    begin
        static logic [3:0]  ra[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
        static logic [31:0] rv[5] = '{32'h00003F1F, 32'h0, 32'h0, 32'h0, 32'h0};
        do_reset();
        for (int i = 0; i < 5; i++)
            rd(ra[i], rv[i]);
        check("ram_user_blocked", 1'b0, ram_user_blocked);
        iop(24'h000000, 1'b1);
        iop(24'h00ABFF, 1'b1);
        eop(24'h00ABFF, 1'b1);
        wr(4'h0, 32'h00000213);
        iop(24'h000000, 1'b0);
        iop(24'h0005FF, 1'b0);
        iop(24'h000600, 1'b1);
        rd(4'h4, 32'h2);
        check("irq", 1'b0, irq);
        wr(4'h8, 32'h2);
        check("irq", 1'b1, irq);
        wr(4'h4, 32'h2);
        check("irq", 1'b0, irq);
        wr(4'h0, 32'h0003301B);
        iop(24'h005FFF, 1'b1);
        iop(24'h006000, 1'b0);
        iop(24'h00ABFF, 1'b0);
        wr(4'h0, 32'h00003F1F);
        rd(4'h0, 32'h0003301B);
        rd(4'h4, 32'h0000000A);
        repeat (4)
        begin
            @(posedge clock);
            check("ser_clock", program_clock_pin[1], ser_clock);
            check("ser_data_in", program_data_pin_in[1], ser_data_in);
            check("pd_oe", {1'b0, ser_data_oe, 1'b0}, pd_oe);
            check("pd_out", {1'b0, ser_data_out, 1'b0}, pd_out);
            check("pin_reserved", 3'b010, pin_reserved);
        end
        ram_addr <= 16'h004F;
        @(posedge clock);
        check("ram_user_blocked", 1'b1, ram_user_blocked);
        ram_addr <= 16'h0050;
        @(posedge clock);
        check("ram_user_blocked", 1'b0, ram_user_blocked);
        do_reset();
        wr(4'h0, 32'h00003F0F);
        iop(24'h00AA00, 1'b0);
        iop(24'h00A9FF, 1'b1);
        do_reset();
        wr(4'h0, 32'h00000211);
        iop(24'h001000, 1'b0);
        eop(24'h001000, 1'b1);
        do_reset();
        wr(4'h0, 32'h00003F1E);
        eop(24'h00ABFF, 1'b0);
        iop(24'h000100, 1'b1);
        rd(4'h4, 32'h1);
        wr(4'hC, 32'h1);
        repeat (2) @(posedge clock);
        check("device_reset_req", 1'b1, device_reset_req);
        rd(4'h4, 32'h5);
        wr(4'h0, 32'h00003F1E);
        repeat (2) @(posedge clock);
        check("device_reset_req", 1'b0, device_reset_req);
        check("commits", commits_exp, i_flash.commits);
        complete_run();
    end
endmodule : pgw_guard_tb_top
